// ### inc/data_move_pkg.sv
// Constants and encodings for the data-move instruction executer.
// Assumes a single clock domain shared by core, memories and bus.
package data_move_pkg;

  // Instruction phases within one instruction cycle
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_LOAD_PTR2 = 2'b01,
    ST_COPY2 = 2'b10
  } seq_t;

  // Opcode prefixes
  localparam logic [9:0] OP_LOAD_PTR = 10'h3B8;
  localparam logic [7:0] OP_LOAD_PTR_WORD2 = 8'hF0;
  localparam logic [5:0] OP_COPY_FILE = 6'h14;
  localparam logic [3:0] OP_COPY_FF_SRC = 4'hC;
  localparam logic [3:0] OP_COPY_FF_DST = 4'hF;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_LOAD_LIT = 8'h0E;

  // Field positions in an instruction word
  localparam int FLD_D = 9;
  localparam int FLD_A = 8;
  localparam int FLD_SEL_HI = 5;
  localparam int FLD_SEL_LO = 4;

  // Addressing
  localparam logic [7:0] ILO_MAX_F = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [1:0] ILO_PTR = 2'h2;
  localparam logic [1:0] PTR_LAST = 2'h2;
  localparam logic [11:0] ACC_ADDR_DEFAULT = 12'hFD0;

  // Register map, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_PTR0 = 8'h10;
  localparam logic [7:0] REG_PTR1 = 8'h14;
  localparam logic [7:0] REG_PTR2 = 8'h18;
  localparam int CTRL_EXT = 0;
  localparam int STAT_Z = 0;
  localparam int STAT_N = 1;
  localparam int STAT_BUSY = 2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### rtl/data_move_exec.sv
// Data-move and pointer-load instruction executer with an AHB-Lite register slave.
// Assumes program memory and data memory on clk_in; data memory answers a read
// in the same clock that data_rd_out is high.
//
// What this block does
// - Two-word pointer load writes the high nibble in cycle one and the low byte in cycle two.
// - Copy-file moves the addressed register to its destination and sets N and Z in one cycle.
// - Copy-file sends its result to the accumulator when d is 0, to the file register when 1.
// - Access bit 0 selects the access bank, bit 1 the bank held in the bank select register.
// - Access bit 0 with the extended set on and f at most 5Fh addresses pointer 2 plus f.
// - File-to-file copy reaches the whole 12-bit data space and changes no flags.
// - File-to-file copy reads in cycle one and writes in the last phase of cycle two only.
// - File-to-file copy accepts the accumulator as source or destination.
// - Load-bank puts its literal in the bank select register in one cycle, flags kept.
// - Load-literal puts its literal into the accumulator in one cycle with flags unchanged.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
module data_move_exec #(
  parameter logic [11:0] ACC_ADDR = data_move_pkg::ACC_ADDR_DEFAULT
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  output logic instr_req_out,
  output logic [11:0] data_addr_out,
  output logic data_rd_out,
  output logic data_wr_out,
  output logic [7:0] data_wdata_out,
  input wire logic [7:0] data_rdata_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  import data_move_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    seq_t seq;
    logic [15:0] ir;
    logic [15:0] word2;
    logic [7:0] opr;
    logic [7:0] acc;
    logic [7:0] bank_select_reg;
    logic [2:0][11:0] ptr;
    logic neg;
    logic zero;
    logic ext_en;
    logic instr_req;
    logic [11:0] daddr;
    logic drd;
    logic dwr;
    logic [7:0] dwdata;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } state_t;

  state_t r;
  state_t next_s;

  logic is_load_ptr;
  logic is_copy_file;
  logic is_copy_ff;
  logic is_load_bank;
  logic is_load_lit;
  logic [1:0] sel;
  logic sel_ok;
  logic [7:0] f;
  logic [11:0] file_addr;
  logic src_is_acc;
  logic dst_is_acc;
  logic bus_take;
  logic [31:0] read_mux;

  // Decode is held on the latched first word for the whole instruction
  assign is_load_ptr = (r.ir[15:6] == OP_LOAD_PTR);
  assign is_copy_file = (r.ir[15:10] == OP_COPY_FILE);
  assign is_copy_ff = (r.ir[15:12] == OP_COPY_FF_SRC);
  assign is_load_bank = (r.ir[15:8] == OP_LOAD_BANK);
  assign is_load_lit = (r.ir[15:8] == OP_LOAD_LIT);
  assign sel = r.ir[FLD_SEL_HI:FLD_SEL_LO];
  assign sel_ok = (sel <= PTR_LAST);
  assign f = r.ir[7:0];
  assign src_is_acc = (r.ir[11:0] == ACC_ADDR);
  assign dst_is_acc = (r.word2[11:0] == ACC_ADDR);

  // Operand address of a byte-oriented instruction
  always_comb begin
    if (r.ir[FLD_A]) begin
      file_addr = {r.bank_select_reg[3:0], f};
    end else if (r.ext_en && (f <= ILO_MAX_F)) begin
      file_addr = r.ptr[ILO_PTR] + {4'h0, f};
    end else if (f <= ILO_MAX_F) begin
      file_addr = {ACCESS_LOW_BANK, f};
    end else begin
      file_addr = {ACCESS_HIGH_BANK, f};
    end
  end

  assign bus_take = hsel_in && htrans_in[1] && hready_in;

  always_comb begin
    read_mux = '0;
    case (haddr_in[7:0])
      REG_CTRL: begin
        read_mux[CTRL_EXT] = r.ext_en;
      end
      REG_STATUS: begin
        read_mux[STAT_Z] = r.zero;
        read_mux[STAT_N] = r.neg;
        read_mux[STAT_BUSY] = (r.seq != ST_FIRST) || (r.phase != PH_DECODE);
      end
      REG_ACC: begin
        read_mux[7:0] = r.acc;
      end
      REG_BANK: begin
        read_mux[7:0] = r.bank_select_reg;
      end
      REG_PTR0: begin
        read_mux[11:0] = r.ptr[0];
      end
      REG_PTR1: begin
        read_mux[11:0] = r.ptr[1];
      end
      REG_PTR2: begin
        read_mux[11:0] = r.ptr[2];
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  always_comb begin
    next_s = r;
    if (ce_in) begin
      next_s.drd = 1'b0;
      next_s.dwr = 1'b0;

      // Register slave: zero wait states, always OKAY
      next_s.hready = 1'b1;
      next_s.hresp = HRESP_OKAY;
      if (r.bus_wr && (r.bus_addr == REG_CTRL)) begin
        next_s.ext_en = hwdata_in[CTRL_EXT];
      end
      next_s.bus_wr = bus_take && hwrite_in;
      next_s.bus_addr = haddr_in[7:0];
      next_s.hrdata = (bus_take && !hwrite_in) ? read_mux : '0;

      case (r.phase)
        PH_DECODE: begin
          // A missing word stalls here instead of running a phantom cycle
          if (instr_valid_in) begin
            if (r.seq == ST_FIRST) begin
              next_s.ir = instr_in;
            end else begin
              next_s.word2 = instr_in;
            end
            next_s.instr_req = 1'b0;
            next_s.phase = PH_READ;
          end
        end
        PH_READ: begin
          next_s.phase = PH_PROC;
          if (r.seq == ST_FIRST) begin
            if (is_copy_file) begin
              next_s.daddr = file_addr;
              next_s.drd = 1'b1;
            end else if (is_copy_ff && !src_is_acc) begin
              next_s.daddr = r.ir[11:0];
              next_s.drd = 1'b1;
            end
          end
        end
        PH_PROC: begin
          next_s.phase = PH_WRITE;
          if ((r.seq == ST_FIRST) && is_copy_file) begin
            next_s.opr = data_rdata_in;
          end else if ((r.seq == ST_FIRST) && is_copy_ff) begin
            next_s.opr = src_is_acc ? r.acc : data_rdata_in;
          end
        end
        PH_WRITE: begin
          next_s.phase = PH_DECODE;
          next_s.instr_req = 1'b1;
          next_s.seq = ST_FIRST;
          case (r.seq)
            ST_FIRST: begin
              if (is_load_ptr) begin
                if (sel_ok) begin
                  next_s.ptr[sel][11:8] = r.ir[3:0];
                end
                next_s.seq = ST_LOAD_PTR2;
              end else if (is_copy_file) begin
                next_s.zero = (r.opr == 8'h00);
                next_s.neg = r.opr[7];
                if (r.ir[FLD_D]) begin
                  next_s.dwr = 1'b1;
                  next_s.dwdata = r.opr;
                end else begin
                  next_s.acc = r.opr;
                end
              end else if (is_copy_ff) begin
                next_s.seq = ST_COPY2;
              end else if (is_load_bank) begin
                next_s.bank_select_reg = {4'h0, r.ir[3:0]};
              end else if (is_load_lit) begin
                next_s.acc = r.ir[7:0];
              end
            end
            ST_LOAD_PTR2: begin
              if (sel_ok) begin
                next_s.ptr[sel][7:0] = r.word2[7:0];
              end
            end
            ST_COPY2: begin
              // Restricted destinations are left to software to avoid
              if (dst_is_acc) begin
                next_s.acc = r.opr;
              end else begin
                next_s.daddr = r.word2[11:0];
                next_s.dwr = 1'b1;
                next_s.dwdata = r.opr;
              end
            end
            default: begin
              next_s.seq = ST_FIRST;
            end
          endcase
        end
        default: begin
          next_s.phase = PH_DECODE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.hready <= 1'b1;
      r.instr_req <= 1'b1;
    end else begin
      r <= next_s;
    end
  end

  assign instr_req_out = r.instr_req;
  assign data_addr_out = r.daddr;
  assign data_rd_out = r.drd;
  assign data_wr_out = r.dwr;
  assign data_wdata_out = r.dwdata;
  assign hrdata_out = r.hrdata;
  assign hreadyout_out = r.hready;
  assign hresp_out = r.hresp;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  AST_PTR_LOW: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_LOAD_PTR2 && sel == ILO_PTR)
    |=> (r.ptr[ILO_PTR][7:0] == $past(r.word2[7:0])) && r.phase == PH_DECODE
  ) else $error("pointer low byte not loaded");

  AST_PTR_HIGH: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_load_ptr && sel == 2'h0)
    |=> (r.ptr[0][11:8] == $past(r.ir[3:0])) && r.seq == ST_LOAD_PTR2
  ) else $error("pointer high nibble not loaded");

  AST_COPY_FILE_FLAGS: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_copy_file)
    |=> (r.zero == ($past(r.opr) == 8'h00)) && (r.neg == $past(r.opr[7]))
  ) else $error("copy-file flags wrong");

  AST_COPY_FILE_DEST: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_copy_file && !r.ir[FLD_D])
    |=> (r.acc == $past(r.opr)) && !data_wr_out
  ) else $error("copy-file to accumulator failed");

  AST_BANKED_ADDR: assert property (
    (ce_in && r.phase == PH_READ && r.seq == ST_FIRST && is_copy_file && r.ir[FLD_A])
    |=> data_rd_out && (data_addr_out == {$past(r.bank_select_reg[3:0]), $past(f)})
  ) else $error("banked address wrong");

  AST_INDEXED_ADDR: assert property (
    (ce_in && r.phase == PH_READ && r.seq == ST_FIRST && is_copy_file && !r.ir[FLD_A]
     && r.ext_en && f <= ILO_MAX_F)
    |=> data_addr_out == $past(r.ptr[ILO_PTR]) + {4'h0, $past(f)}
  ) else $error("indexed address wrong");

  AST_COPY_FF_NO_READ: assert property (
    (ce_in && r.phase == PH_READ && r.seq == ST_COPY2) |=> !data_rd_out
  ) else $error("read issued in second copy cycle");

  AST_COPY_FF_WRITE: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_COPY2 && !dst_is_acc)
    |=> data_wr_out && (data_addr_out == $past(r.word2[11:0])) && $stable(r.zero)
        && $stable(r.neg)
  ) else $error("file-to-file write wrong");

  AST_LOAD_BANK: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_load_bank)
    |=> (r.bank_select_reg[7:4] == 4'h0) && (r.bank_select_reg[3:0] == $past(r.ir[3:0])) && $stable(r.zero)
  ) else $error("bank select load wrong");

  AST_LOAD_LIT: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_load_lit)
    |=> (r.acc == $past(r.ir[7:0])) && $stable(r.neg) && $stable(r.zero)
  ) else $error("literal load wrong");

  AST_PHASE_ORDER: assert property (
    (ce_in && r.phase == PH_READ) |=> r.phase == PH_PROC
  ) else $error("phase order broken");

  AST_COPY_FILE_WRBACK: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_FIRST && is_copy_file && r.ir[FLD_D])
    |=> data_wr_out && (data_wdata_out == $past(r.opr)) && $stable(r.acc)
  ) else $error("copy-file write-back failed");

  AST_COPY_FF_TO_ACC: assert property (
    (ce_in && r.phase == PH_WRITE && r.seq == ST_COPY2 && dst_is_acc)
    |=> (r.acc == $past(r.opr)) && !data_wr_out && $stable(r.zero)
  ) else $error("file-to-file copy into accumulator failed");

  // Zero wait states keep the master simple; a slower slave would need a stall path here
  AST_BUS_OKAY: assert property (
    hreadyout_out && (hresp_out == HRESP_OKAY)
  ) else $error("register slave stalled or erred");

  AST_FREEZE: assert property (
    !ce_in |=> $stable(r)
  ) else $error("state moved on a disabled clock");

endmodule

// ### verification/prog_data_mem.sv
// Partner model: program memory feeding words and data memory on clk_in.
// Follows the core's ce_in: only the pushed-word count moves on a disabled clock.
module prog_data_mem (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic instr_req_in,
  input wire logic data_rd_in,
  input wire logic data_wr_in,
  input wire logic [11:0] data_addr_in,
  input wire logic [7:0] data_wdata_in,
  output logic [15:0] instr_out,
  output logic instr_valid_out,
  output logic [7:0] data_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] prog [0:63];
  logic [7:0] mem [0:4095];
  logic [11:0] last_wa = 12'h000;
  logic [7:0] last_rd = 8'h00;
  int len = 0;
  int avail = 0;
  int pc = 0;
  int rd_cnt = 0;
  assign instr_valid_out = pc < avail;
  // Idle bus shows inverted data so a stale word is never mistaken for a fresh one
  assign instr_out = instr_valid_out ? prog[pc] : ~prog[pc % 64];
  assign data_rdata_out = data_rd_in ? mem[data_addr_in] : ~last_rd;
  always @(posedge clk_in) begin
    // Pushed words appear only after an edge, so core and model never race a push
    avail <= len;
    if (ce_in && instr_req_in && instr_valid_out) pc <= pc + 1;
    if (ce_in && data_rd_in) begin
      rd_cnt <= rd_cnt + 1;
      last_rd <= mem[data_addr_in];
    end
    if (ce_in && data_wr_in) begin
      mem[data_addr_in] <= data_wdata_in;
      last_wa <= data_addr_in;
    end
  end
  task automatic push(input logic [15:0] w);
    prog[len] = w;
    len++;
  endtask
endmodule

// ### verification/tb_data_move_instruction_exec.sv
// Self-checking bench: AHB-Lite register reads and instruction programs.
// Assumes prog_data_mem as the far side and a zero-wait-state register slave.
module tb_data_move_instruction_exec;
  timeunit 1ns;
  timeprecision 1ns;
  import data_move_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ce = 1'b1;
  logic [2:0] hsize = 3'h2;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, req, rd, wr, valid;
  logic [15:0] instr;
  logic [11:0] daddr;
  logic [7:0] wdata, rdata;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 clk_in = ~clk_in;
  data_move_exec i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
    .instr_in(instr), .instr_valid_in(valid), .instr_req_out(req),
    .data_addr_out(daddr), .data_rd_out(rd), .data_wr_out(wr),
    .data_wdata_out(wdata), .data_rdata_in(rdata), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));
  prog_data_mem i_mem (.clk_in(clk_in), .ce_in(ce), .instr_req_in(req), .data_rd_in(rd),
    .data_wr_in(wr), .data_addr_in(daddr), .data_wdata_in(wdata),
    .instr_out(instr), .instr_valid_out(valid), .data_rdata_out(rdata));
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hready !== 1'b1);
    rdv = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask
  // Waits for the last pushed word to be taken and its instruction cycle to end
  task automatic run(input string name);
    while (i_mem.pc != i_mem.len) @(posedge clk_in);
    @(posedge clk_in);
    while (req !== 1'b1) @(posedge clk_in);
    @(posedge clk_in);
    $display("test %s done", name);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  logic [11:0] kv [0:2] = '{12'hFFF, 12'h001, 12'h3AB};
  logic [31:0] dummy;
  int n0;
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rchk(REG_CTRL, 32'h0);
    rchk(REG_STATUS, 32'h0);
    rchk(REG_ACC, 32'h0);
    rchk(8'h40, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      i_mem.push({8'hEE, 2'b00, 2'(i), kv[i][11:8]});
      i_mem.push({8'hF0, kv[i][7:0]});
    end
    run("pointer");
    for (int i = 0; i < 3; i++) rchk(REG_PTR0 + 8'(4 * i), {20'h0, kv[i]});
    i_mem.push(16'h01A7);
    run("bank");
    rchk(REG_BANK, 32'h7);
    i_mem.mem[12'h734] = 8'h80;
    i_mem.push(16'h5134);
    run("copy_acc");
    rchk(REG_ACC, 32'h80);
    rchk(REG_STATUS, 32'h2);
    i_mem.push(16'h0E5A);
    run("literal");
    rchk(REG_ACC, 32'h5A);
    rchk(REG_STATUS, 32'h2);
    i_mem.mem[12'hF90] = 8'h00;
    i_mem.push(16'h5290);
    run("copy_back");
    chk({20'h0, i_mem.last_wa}, 32'hF90);
    rchk(REG_STATUS, 32'h1);
    rchk(REG_ACC, 32'h5A);
    // Destinations stay clear of program counter and stack-top bytes
    i_mem.mem[12'h123] = 8'h5C;
    n0 = i_mem.rd_cnt;
    i_mem.push(16'hC123);
    i_mem.push(16'hF456);
    run("f2f");
    chk({24'h0, i_mem.mem[12'h456]}, 32'h5C);
    chk(i_mem.rd_cnt - n0, 1);
    rchk(REG_STATUS, 32'h1);
    i_mem.push({4'hC, ACC_ADDR_DEFAULT});
    i_mem.push(16'hF000);
    i_mem.push(16'hC456);
    i_mem.push({4'hF, ACC_ADDR_DEFAULT});
    run("f2f_acc");
    chk({24'h0, i_mem.mem[12'h000]}, 32'h5A);
    rchk(REG_ACC, 32'h5C);
    // A frozen core must leave a waiting word untaken
    ce <= 1'b0;
    i_mem.push(16'h0E33);
    repeat (3) @(posedge clk_in);
    chk({31'h0, req}, 32'h1);
    chk(i_mem.pc, i_mem.len - 1);
    ce <= 1'b1;
    run("freeze");
    rchk(REG_ACC, 32'h33);
    bus(1'b1, REG_CTRL, 32'h1, dummy);
    rchk(REG_CTRL, 32'h1);
    i_mem.mem[12'h3BB] = 8'h42;
    i_mem.push(16'h5010);
    run("indexed");
    rchk(REG_ACC, 32'h42);
    test_done();
  end
endmodule
